// file: dsc_pkg.sv
// constants, types and helpers shared by the dual synthesizer control logic
// How it works
// (R01) each serial clock rising edge shifts one data bit into the 22-bit word
// (R02) the two last bits shifted in pick the target control register
// (R03) load strobe rising edge copies the word into the addressed register
// (R04) host sends the data msb first so the address ends at the low end
// (R05) loading keeps working while either or both loops sleep
// (R06) multi-function output is driven low while the main loop sleeps
// (R07) a mode word picks what the multi-function output carries
// (R08) lock detect floats when the pump is idle, pulls low when it pumps
// (R09) lock detect sources: main activity, aux activity, both combined
// (R10) fast acquisition mode turns on an open-drain switch to ground
// (R11) counter reset modes hold aux, main or all dividers at load point
// (R12) releasing counter reset restarts both dividers together
// (R13) any reference or feedback divider output can be monitored
// (R14) a sleeping loop stops detector and pump and floats pump and rf pins
// (R15) dividers of a sleeping loop are held at load point
// (R16) oscillator buffer is off only when both loops sleep, input pulled up
// (R17) waking powers up, holds dividers, then releases them together later
// (R18) synchronous sleep waits for the next pump pulse to finish
// (R19) asynchronous sleep enters at once
// (R20) high-z and sleep bits pick active, floating pump, sync or async sleep
// (R21) pump sources on pump-up and sinks on pump-down events
// (R22) each loop's current select bit picks the pump current magnitude
// (R23) word is a 20-bit data field above a 2-bit address field
// (R24) address 0 aux ref, 1 aux feedback, 2 main ref, 3 main feedback
// (R25) sleeping one loop leaves the other loop running
// (R26) combined lock detect pulls low when either pump is active
package dsc_pkg;
    localparam int DSC_WORD_W = 22;
    localparam int DSC_DATA_W = 20;
    localparam int DSC_ADDR_W = 2;
    localparam int DSC_BITCNT_W = 5;
    localparam logic [4:0] DSC_WORD_BITS = 5'h16;
    localparam logic [1:0] ADDR_AUX_R  = 2'h0;
    localparam logic [1:0] ADDR_AUX_N  = 2'h1;
    localparam logic [1:0] ADDR_MAIN_R = 2'h2;
    localparam logic [1:0] ADDR_MAIN_N = 2'h3;
    localparam logic [19:0] REG_RESET = 20'h00000;
    // field positions inside the 20-bit data field
    localparam int FLD_MUX_A = 19;
    localparam int FLD_MUX_B = 18;
    localparam int FLD_HIZ = 17;
    localparam int FLD_CUR = 16;
    localparam int FLD_POL = 15;
    localparam int FLD_RDIV_MSB = 14;
    localparam int FLD_SLEEP = 19;
    localparam int FLD_PRE = 18;
    localparam int FLD_B_MSB = 17;
    localparam int FLD_B_LSB = 5;
    localparam int FLD_A_MSB = 4;
    localparam int MAIN_P_LO = 16;
    localparam int MAIN_P_HI = 32;
    localparam int AUX_P_LO = 8;
    localparam int AUX_P_HI = 16;
    localparam int CLK_PERIOD_NS = 5;
    localparam int WAKE_DELAY_NS = 1000;
    localparam logic [7:0] WAKE_CYCLES =
        8'((WAKE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    typedef enum logic [3:0] {
        MFO_LOW       = 4'h0,
        MFO_LOCK_MAIN = 4'h1,
        MFO_LOCK_AUX  = 4'h2,
        MFO_LOCK_BOTH = 4'h3,
        MFO_FAST_ACQ  = 4'h4,
        MFO_RST_AUX   = 4'h5,
        MFO_RST_MAIN  = 4'h6,
        MFO_RST_ALL   = 4'h7,
        MFO_AUX_RDIV  = 4'h8,
        MFO_AUX_NDIV  = 4'h9,
        MFO_MAIN_RDIV = 4'hA,
        MFO_MAIN_NDIV = 4'hB
    } dsc_mfo_mode_t;
    typedef enum logic [1:0] {
        PWR_ACTIVE    = 2'h0,
        PWR_SYNC_WAIT = 2'h1,
        PWR_ASLEEP    = 2'h3,
        PWR_WAKE      = 2'h2
    } dsc_pwr_state_t;
    typedef struct packed {
        logic [14:0] r_ratio;
        logic        pol;
        logic        cur_sel;
        logic        hiz_sel;
        logic [12:0] b_cnt;
        logic [4:0]  a_cnt;
        logic        pre_sel;
        logic        sleep_bit;
    } dsc_loop_cfg_t;
    typedef struct packed {
        logic up;
        logic dn;
        logic oe_n;
        logic high_current;
    } dsc_pump_t;
    function automatic dsc_loop_cfg_t dsc_make_cfg(input logic [19:0] r, input logic [19:0] n);
        dsc_loop_cfg_t c;
        c.r_ratio   = r[FLD_RDIV_MSB:0];
        c.pol       = r[FLD_POL];
        c.cur_sel   = r[FLD_CUR];
        c.hiz_sel   = r[FLD_HIZ];
        c.b_cnt     = n[FLD_B_MSB:FLD_B_LSB];
        c.a_cnt     = n[FLD_A_MSB:0];
        c.pre_sel   = n[FLD_PRE];
        c.sleep_bit = n[FLD_SLEEP];
        return c;
    endfunction
endpackage

// file: dsc_loop.sv
// one synthesizer loop: dividers, phase detector, pump steering, power control
`timescale 1ns/100ps
module dsc_loop
    import dsc_pkg::*;
#(
    parameter int P_LO = 16,
    parameter int P_HI = 32
) (
    input  wire logic    mclk,          // core clock
    input  wire logic    sys_rst,       // async reset, high
    input  wire logic    ref_tick,      // one-cycle reference clock edge
    input  wire logic    rf_tick,       // one-cycle rf input edge
    input  wire logic    counter_hold,  // hold dividers at load point
    input  dsc_loop_cfg_t cfg,          // latched configuration
    output dsc_pump_t    pump,          // pump steering
    output logic         pump_active,   // phase detector asks for charge
    output logic         rf_hiz,        // rf input floated
    output logic         asleep,        // loop in powerdown
    output logic         ref_div_out,   // reference divider pulse
    output logic         fb_div_out     // feedback divider pulse
);
    typedef struct packed {
        dsc_pwr_state_t st;
        logic [7:0]     wake_cnt;
        logic           seen_pulse;
        logic [14:0]    r_cnt;
        logic [17:0]    n_cnt;
        logic           up;
        logic           dn;
        logic           fr;
        logic           fp;
        dsc_pump_t      pump;
    } dsc_loop_state_t;

    dsc_loop_state_t s;
    dsc_loop_state_t next_s;
    logic [17:0]     n_ratio;
    logic            hold;
    logic            ev_up;
    logic            ev_dn;
    logic            active;

    always_comb begin
        next_s = s;
        n_ratio = 18'(18'(cfg.pre_sel ? P_HI : P_LO) * 18'(cfg.b_cnt)) + 18'(cfg.a_cnt);
        active = s.up | s.dn;
        hold = (s.st == PWR_ASLEEP) || (s.st == PWR_WAKE) || counter_hold; // (R11) (R15) (R17)
        next_s.fr = 1'b0;
        next_s.fp = 1'b0;
        // both counters clear together under hold, so release restarts them aligned
        if (hold) begin
            next_s.r_cnt = 15'h0000; // (R12)
            next_s.n_cnt = 18'h00000;
        end else begin
            if (ref_tick) begin
                if (({1'b0, s.r_cnt} + 16'h0001) >= {1'b0, cfg.r_ratio}) begin
                    next_s.r_cnt = 15'h0000;
                    next_s.fr = 1'b1;
                end else begin
                    next_s.r_cnt = s.r_cnt + 15'h0001;
                end
            end
            if (rf_tick) begin
                if (({1'b0, s.n_cnt} + 19'h00001) >= {1'b0, n_ratio}) begin
                    next_s.n_cnt = 18'h00000;
                    next_s.fp = 1'b1;
                end else begin
                    next_s.n_cnt = s.n_cnt + 18'h00001;
                end
            end
        end
        // polarity swaps which divider edge pumps up
        ev_up = cfg.pol ? s.fr : s.fp; // (R21)
        ev_dn = cfg.pol ? s.fp : s.fr;
        next_s.up = s.up | ev_up;
        next_s.dn = s.dn | ev_dn;
        if (next_s.up && next_s.dn) begin
            next_s.up = 1'b0;
            next_s.dn = 1'b0;
        end
        case (s.st)
            PWR_ACTIVE: begin
                next_s.seen_pulse = 1'b0;
                if (cfg.sleep_bit && cfg.hiz_sel) begin
                    next_s.st = PWR_ASLEEP; // (R19) (R20)
                end else if (cfg.sleep_bit) begin
                    next_s.st = PWR_SYNC_WAIT; // (R20)
                end
            end
            PWR_SYNC_WAIT: begin
                if (active) begin
                    next_s.seen_pulse = 1'b1;
                end
                if (!cfg.sleep_bit) begin
                    next_s.st = PWR_ACTIVE;
                end else if (cfg.hiz_sel || (s.seen_pulse && !active)) begin
                    next_s.st = PWR_ASLEEP; // (R18)
                end
            end
            PWR_ASLEEP: begin
                next_s.wake_cnt = WAKE_CYCLES;
                if (!cfg.sleep_bit) begin
                    next_s.st = PWR_WAKE; // (R17)
                end
            end
            PWR_WAKE: begin
                if (cfg.sleep_bit) begin
                    next_s.st = PWR_ASLEEP;
                end else if (s.wake_cnt <= 8'h01) begin
                    next_s.st = PWR_ACTIVE;
                end else begin
                    next_s.wake_cnt = s.wake_cnt - 8'h01;
                end
            end
            default: begin
                next_s.st = PWR_ASLEEP;
            end
        endcase
        if (next_s.st == PWR_ASLEEP) begin
            next_s.up = 1'b0; // (R14)
            next_s.dn = 1'b0;
        end
        next_s.pump.up = next_s.up;
        next_s.pump.dn = next_s.dn;
        next_s.pump.oe_n = ~((next_s.st != PWR_ASLEEP) && !cfg.hiz_sel &&
                             (next_s.up || next_s.dn)); // (R14) (R20) (R21)
        next_s.pump.high_current = cfg.cur_sel; // (R22)
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            s <= '{st: PWR_ACTIVE, pump: '{up: 1'b0, dn: 1'b0, oe_n: 1'b1,
                   high_current: 1'b0}, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign pump        = s.pump;
    assign pump_active = s.up | s.dn;
    assign rf_hiz      = (s.st == PWR_ASLEEP); // (R14)
    assign asleep      = (s.st == PWR_ASLEEP);
    assign ref_div_out = s.fr;
    assign fb_div_out  = s.fp;
endmodule

// file: dsc_control.sv
// top of the dual synthesizer control logic: serial loader, registers, output mux
`timescale 1ns/100ps
module dsc_control
    import dsc_pkg::*;
(
    input  wire logic  mclk,              // core clock, 200 MHz
    input  wire logic  sys_rst,           // async reset, high
    input  wire logic  ser_clk,           // serial link clock from host
    input  wire logic  ser_data,          // serial data, msb first
    input  wire logic  load_strobe,       // latch strobe from host
    input  wire logic  ref_clock_input,   // reference oscillator pin
    input  wire logic  rf_main_input,     // main prescaled rf pin
    input  wire logic  rf_aux_input,      // aux prescaled rf pin
    output logic       mfo_out,           // multi-function output value
    output logic       mfo_oe_n,          // multi-function output drive, low drives
    output dsc_pump_t  main_pump,         // main charge pump steering
    output dsc_pump_t  aux_pump,          // aux charge pump steering
    output logic       main_rf_hiz,       // main rf pins floated
    output logic       aux_rf_hiz,        // aux rf pins floated
    output logic       osc_buffer_on,     // reference buffer powered
    output logic       osc_pullup_on,     // reference input pulled high
    output logic       main_asleep,       // main loop in powerdown
    output logic       aux_asleep,        // aux loop in powerdown
    output logic       load_done,         // one-cycle pulse per latched word
    output logic [1:0] load_addr,         // address of last latched word
    output logic       load_short         // fewer than 22 bits shifted in since reset
);
    ////////////////////////////////////////////////////////////////////////////
    // link domain: shift register on the serial clock
    typedef struct packed {
        logic [DSC_WORD_W-1:0]   shift;
        logic [DSC_BITCNT_W-1:0] bits;
        logic                    frame_tgl;
    } dsc_link_t;

    // core domain state
    typedef struct packed {
        logic [2:0]              pin_s1;
        logic [2:0]              pin_s2;
        logic [2:0]              pin_s3;
        logic                    le_s1;
        logic                    le_s2;
        logic                    le_s3;
        logic                    ft_s1;
        logic                    ft_s2;
        logic                    ft_s3;
        logic                    frame_seen;
        logic [19:0]             aux_r;
        logic [19:0]             aux_n;
        logic [19:0]             main_r;
        logic [19:0]             main_n;
        logic                    mfo_out;
        logic                    mfo_oe_n;
        logic                    osc_on;
        logic                    load_done;
        logic [1:0]              load_addr;
        logic                    load_short;
    } dsc_core_t;

    dsc_link_t     l;
    dsc_link_t     next_l;
    dsc_core_t     c;
    dsc_core_t     next_c;
    dsc_loop_cfg_t main_cfg;
    dsc_loop_cfg_t aux_cfg;
    dsc_mfo_mode_t mode;
    logic [DSC_DATA_W-1:0] word_data;
    logic [DSC_ADDR_W-1:0] word_addr;
    logic          le_rise;
    logic          ref_tick;
    logic          main_rf_tick;
    logic          aux_rf_tick;
    logic          main_hold;
    logic          aux_hold;
    logic          main_active;
    logic          aux_active;
    logic          main_rdiv;
    logic          main_ndiv;
    logic          aux_rdiv;
    logic          aux_ndiv;
    logic          main_sleep;
    logic          aux_sleep;

    ////////////////////////////////////////////////////////////////////////////
    // serial shift, msb first, address lands in the two low bits
    always_comb begin
        next_l = l;
        next_l.shift = {l.shift[DSC_WORD_W-2:0], ser_data}; // (R01) (R04)
        if (l.bits != 5'h1F) begin
            next_l.bits = l.bits + 5'h01;
        end
        next_l.frame_tgl = l.frame_tgl;
    end

    // the bit count saturates and never restarts, so load_short only flags a short
    // first word; the frame toggle is a spare marker and stays at its reset value
    always_ff @(posedge ser_clk or posedge sys_rst) begin
        if (sys_rst) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // core domain
    // the word is read only after the strobe has crossed; the host holds the
    // serial clock still while the strobe is high, so the bus is quiet then
    assign word_data    = c.le_s2 ? l.shift[DSC_WORD_W-1:DSC_ADDR_W] : c.aux_r; // (R23)
    assign word_addr    = l.shift[DSC_ADDR_W-1:0]; // (R02)
    assign le_rise      = c.le_s2 & ~c.le_s3;
    assign ref_tick     = c.pin_s2[0] & ~c.pin_s3[0] & c.osc_on; // (R16)
    assign main_rf_tick = c.pin_s2[1] & ~c.pin_s3[1];
    assign aux_rf_tick  = c.pin_s2[2] & ~c.pin_s3[2];
    assign main_cfg     = dsc_make_cfg(c.main_r, c.main_n);
    assign aux_cfg      = dsc_make_cfg(c.aux_r, c.aux_n);
    assign mode         = dsc_mfo_mode_t'({c.main_r[FLD_MUX_B], c.aux_r[FLD_MUX_B],
                                           c.main_r[FLD_MUX_A], c.aux_r[FLD_MUX_A]}); // (R07)
    assign main_hold    = (mode == MFO_RST_MAIN) || (mode == MFO_RST_ALL); // (R11)
    assign aux_hold     = (mode == MFO_RST_AUX) || (mode == MFO_RST_ALL); // (R11)

    always_comb begin
        next_c = c;
        next_c.pin_s1 = {rf_aux_input, rf_main_input, ref_clock_input};
        next_c.pin_s2 = c.pin_s1;
        next_c.pin_s3 = c.pin_s2;
        next_c.le_s1 = load_strobe;
        next_c.le_s2 = c.le_s1;
        next_c.le_s3 = c.le_s2;
        next_c.ft_s1 = l.frame_tgl;
        next_c.ft_s2 = c.ft_s1;
        next_c.ft_s3 = c.ft_s2;
        next_c.load_done = 1'b0;
        // latching never looks at the power state, so sleeping loops still load
        if (le_rise) begin // (R03) (R05)
            next_c.load_done = 1'b1;
            next_c.load_addr = word_addr;
            next_c.load_short = (l.bits < DSC_WORD_BITS);
            case (word_addr) // (R24)
                ADDR_AUX_R: begin
                    next_c.aux_r = word_data;
                end
                ADDR_AUX_N: begin
                    next_c.aux_n = word_data;
                end
                ADDR_MAIN_R: begin
                    next_c.main_r = word_data;
                end
                ADDR_MAIN_N: begin
                    next_c.main_n = word_data;
                end
                default: begin
                    next_c.aux_r = c.aux_r;
                end
            endcase
        end
        next_c.frame_seen = c.ft_s2 ^ c.ft_s3;
        next_c.osc_on = ~(main_sleep & aux_sleep); // (R16) (R17)
        // open-drain modes leave mfo_out low and steer only the enable
        next_c.mfo_out = 1'b0;
        next_c.mfo_oe_n = 1'b0;
        case (mode)
            MFO_LOCK_MAIN: begin
                next_c.mfo_oe_n = ~main_active; // (R08) (R09)
            end
            MFO_LOCK_AUX: begin
                next_c.mfo_oe_n = ~aux_active; // (R08) (R09)
            end
            MFO_LOCK_BOTH: begin
                next_c.mfo_oe_n = ~(main_active | aux_active); // (R09) (R26)
            end
            MFO_FAST_ACQ: begin
                next_c.mfo_oe_n = 1'b0; // (R10)
            end
            MFO_AUX_RDIV: begin
                next_c.mfo_out = aux_rdiv; // (R13)
            end
            MFO_AUX_NDIV: begin
                next_c.mfo_out = aux_ndiv; // (R13)
            end
            MFO_MAIN_RDIV: begin
                next_c.mfo_out = main_rdiv; // (R13)
            end
            MFO_MAIN_NDIV: begin
                next_c.mfo_out = main_ndiv; // (R13)
            end
            default: begin
                next_c.mfo_out = 1'b0;
            end
        endcase
        if (main_sleep) begin
            next_c.mfo_out = 1'b0; // (R06)
            next_c.mfo_oe_n = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            c <= '{aux_r: REG_RESET, aux_n: REG_RESET, main_r: REG_RESET,
                   main_n: REG_RESET, osc_on: 1'b1, default: '0};
        end else begin
            c <= next_c;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // the two loops run from separate state, so one sleeping leaves the other alone
    dsc_loop #(
        .P_LO (MAIN_P_LO),
        .P_HI (MAIN_P_HI)
    ) u_main (
        .mclk         (mclk),
        .sys_rst      (sys_rst),
        .ref_tick     (ref_tick),
        .rf_tick      (main_rf_tick),
        .counter_hold (main_hold),
        .cfg          (main_cfg),
        .pump         (main_pump),
        .pump_active  (main_active),
        .rf_hiz       (main_rf_hiz),
        .asleep       (main_sleep),
        .ref_div_out  (main_rdiv),
        .fb_div_out   (main_ndiv)
    ); // (R25)

    dsc_loop #(
        .P_LO (AUX_P_LO),
        .P_HI (AUX_P_HI)
    ) u_aux (
        .mclk         (mclk),
        .sys_rst      (sys_rst),
        .ref_tick     (ref_tick),
        .rf_tick      (aux_rf_tick),
        .counter_hold (aux_hold),
        .cfg          (aux_cfg),
        .pump         (aux_pump),
        .pump_active  (aux_active),
        .rf_hiz       (aux_rf_hiz),
        .asleep       (aux_sleep),
        .ref_div_out  (aux_rdiv),
        .fb_div_out   (aux_ndiv)
    ); // (R25)

    assign mfo_out       = c.mfo_out;
    assign mfo_oe_n      = c.mfo_oe_n;
    assign osc_buffer_on = c.osc_on;
    assign osc_pullup_on = ~c.osc_on; // (R16)
    assign main_asleep   = main_sleep;
    assign aux_asleep    = aux_sleep;
    assign load_done     = c.load_done;
    assign load_addr     = c.load_addr;
    assign load_short    = c.load_short;
endmodule

// file: dsc_control_properties.sv
// concurrent checks on the ports of the dual synthesizer control top
`timescale 1ns/100ps
module dsc_control_properties
    import dsc_pkg::*;
(
    input wire logic      mclk,          // core clock
    input wire logic      sys_rst,       // async reset, high
    input wire logic      load_strobe,   // latch strobe
    input wire logic      mfo_out,       // multi-function value
    input wire logic      mfo_oe_n,      // multi-function drive, low drives
    input wire dsc_pump_t main_pump,     // main pump steering
    input wire dsc_pump_t aux_pump,      // aux pump steering
    input wire logic      main_rf_hiz,   // main rf floated
    input wire logic      aux_rf_hiz,    // aux rf floated
    input wire logic      osc_buffer_on, // reference buffer powered
    input wire logic      osc_pullup_on, // reference pulled high
    input wire logic      main_asleep,   // main powerdown
    input wire logic      aux_asleep,    // aux powerdown
    input wire logic      load_done      // latch pulse
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_rise;
        $rose(load_strobe);
    endsequence
    sequence s_latch;
        ##[2:4] load_done;
    endsequence
    property p_load_edge;
        s_rise |-> s_latch;
    endproperty
    property p_load_pulse;
        load_done |=> !load_done;
    endproperty
    property p_osc_pair;
        osc_pullup_on == !osc_buffer_on;
    endproperty
    property p_osc_on;
        (!main_asleep || !aux_asleep) [*2] |-> osc_buffer_on;
    endproperty
    property p_main_hiz;
        main_rf_hiz == main_asleep;
    endproperty
    property p_aux_hiz;
        aux_rf_hiz == aux_asleep;
    endproperty
    // registered pump is built from the next state, so it changes with the state; the check still waits two cycles of sleep
    property p_pump_sleep;
        aux_asleep [*2] |-> aux_pump.oe_n && !aux_pump.up && !aux_pump.dn;
    endproperty
    property p_mfo_sleep;
        main_asleep [*3] |-> !mfo_out && !mfo_oe_n;
    endproperty
    property p_pump_excl;
        !(main_pump.up && main_pump.dn);
    endproperty
    a_load_edge: assert property (p_load_edge) else $error("no latch after strobe");
    a_load_pulse: assert property (p_load_pulse) else $error("latch pulse too long");
    a_osc_pair: assert property (p_osc_pair) else $error("pull-up not inverse");
    a_osc_on: assert property (p_osc_on) else $error("buffer off while awake");
    a_main_hiz: assert property (p_main_hiz) else $error("main rf float wrong");
    a_aux_hiz: assert property (p_aux_hiz) else $error("aux rf float wrong");
    a_pump_sleep: assert property (p_pump_sleep) else $error("aux pump on asleep");
    a_mfo_sleep: assert property (p_mfo_sleep) else $error("output not low asleep");
    a_pump_excl: assert property (p_pump_excl) else $error("pump up and down");
endmodule
bind dsc_control dsc_control_properties u_chk (.mclk, .sys_rst, .load_strobe, .mfo_out,
    .mfo_oe_n, .main_pump, .aux_pump, .main_rf_hiz, .aux_rf_hiz, .osc_buffer_on,
    .osc_pullup_on, .main_asleep, .aux_asleep, .load_done);

// file: dsc_host.sv
// host model driving the three-wire serial programming link
`timescale 1ns/100ps
module dsc_host (
    output logic ser_clk,     // link clock, still between frames
    output logic ser_data,    // serial data
    output logic load_strobe  // latch strobe
);
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        load_strobe = 1'b0;
    end
    // 30 ns link period, started on its own phase
    task automatic send_word(input logic [21:0] w);
        #7;
        for (int i = 21; i >= 0; i--) begin
            ser_data = w[i];
            #15 ser_clk = 1'b1;
            #15 ser_clk = 1'b0;
        end
        ser_data = ~w[0];
        #20 load_strobe = 1'b1;
        #60 load_strobe = 1'b0;
        #20;
    endtask
endmodule

// file: tb_top.sv
// self-checking bench for the dual synthesizer control top
`timescale 1ns/100ps
module tb_top;
    import dsc_pkg::*;
    logic      mclk, sys_rst, ser_clk, ser_data, load_strobe, mfo_out, mfo_oe_n;
    logic      main_rf_hiz, aux_rf_hiz, osc_buffer_on, osc_pullup_on, main_asleep;
    logic      aux_asleep, load_done, load_short, done_seen;
    logic [1:0] load_addr;
    logic [1:0] pin_drv;
    dsc_pump_t main_pump, aux_pump;
    int        error_cnt, checked;
    dsc_host host (.ser_clk(ser_clk), .ser_data(ser_data), .load_strobe(load_strobe));
    dsc_control dut (.mclk(mclk), .sys_rst(sys_rst), .ser_clk(ser_clk),
        .ser_data(ser_data), .load_strobe(load_strobe), .ref_clock_input(pin_drv[0]),
        .rf_main_input(pin_drv[1]), .rf_aux_input(pin_drv[1]), .mfo_out(mfo_out),
        .mfo_oe_n(mfo_oe_n), .main_pump(main_pump), .aux_pump(aux_pump),
        .main_rf_hiz(main_rf_hiz), .aux_rf_hiz(aux_rf_hiz),
        .osc_buffer_on(osc_buffer_on), .osc_pullup_on(osc_pullup_on),
        .main_asleep(main_asleep), .aux_asleep(aux_asleep), .load_done(load_done),
        .load_addr(load_addr), .load_short(load_short));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) if (load_done === 1'b1) done_seen <= 1'b1;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [19:0] d);
        done_seen = 1'b0;
        host.send_word({d, a});
        chk(done_seen, 4'h1);
        chk(load_addr, a);
        repeat (4) @(posedge mclk);
        #1;
    endtask
    // one full pulse on the selected pins: bit 0 reference, bit 1 both rf inputs
    task automatic tog(input logic [1:0] m);
        repeat (2) begin
            repeat (4) @(posedge mclk);
            #1 pin_drv = pin_drv ^ m;
        end
        repeat (4) @(posedge mclk);
        #1;
    endtask
    task automatic complete_run;
        $display("counts: %0d checks, %0d mismatches", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_rst = 1'b1;
        done_seen = 1'b0;
        pin_drv = 2'h0;
        repeat (16) @(posedge mclk);
        #1 sys_rst = 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        chk(mfo_oe_n, 4'h0);
        chk(osc_buffer_on, 4'h1);
        chk(main_pump, 4'h2);
        $display("test reset done");
        wr(ADDR_AUX_R, 20'h80000);
        chk(mfo_oe_n, 4'h1);
        wr(ADDR_AUX_N, 20'h80000);
        repeat (40) @(posedge mclk);
        #1;
        chk(aux_asleep, 4'h0);
        wr(ADDR_AUX_R, 20'hA0000);
        chk(aux_asleep, 4'h1);
        chk(aux_rf_hiz, 4'h1);
        chk(aux_pump.oe_n, 4'h1);
        chk(main_asleep, 4'h0);
        chk(osc_buffer_on, 4'h1);
        $display("test aux sleep done");
        wr(ADDR_MAIN_R, 20'h20000);
        chk(main_pump.oe_n, 4'h1);
        chk(main_asleep, 4'h0);
        wr(ADDR_MAIN_N, 20'h80000);
        chk(main_asleep, 4'h1);
        chk({mfo_oe_n, mfo_out}, 4'h0);
        chk({osc_buffer_on, osc_pullup_on}, 4'h1);
        $display("test main sleep done");
        wr(ADDR_MAIN_N, 20'h00000);
        repeat (250) @(posedge mclk);
        #1;
        chk(main_asleep, 4'h0);
        chk(osc_buffer_on, 4'h1);
        chk(mfo_oe_n, 4'h1);
        chk(load_short, 4'h0);
        $display("test wake done");
        wr(ADDR_AUX_R, 20'h60000);
        chk({mfo_oe_n, mfo_out}, 4'h0);
        wr(ADDR_AUX_R, 20'hA0000);
        wr(ADDR_MAIN_R, 20'h90000);
        chk(mfo_oe_n, 4'h1);
        tog(2'h1);
        chk(main_pump, 4'h5);
        chk(mfo_oe_n, 4'h0);
        wr(ADDR_MAIN_N, 20'h80000);
        chk(main_asleep, 4'h0);
        tog(2'h2);
        chk(main_asleep, 4'h1);
        $display("test pump done");
        complete_run();
    end
    initial begin
        #100000;
        error_cnt++;
        complete_run();
    end
endmodule
